// ==== rtl/fec_error_monitor_regs.sv ====
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module fec_error_monitor_regs
	import fec_mon_pkg::*;
#(
	parameter int ERR_W = 16
) (
	// Clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              rstn_in,
	// Avalon-MM slave
	input  wire logic [7:0]        address_in,
	input  wire logic              read_in,
	input  wire logic              write_in,
	input  wire logic [7:0]        writedata_in,
	output logic      [7:0]        readdata_out,
	output logic                   waitrequest_out,
	// Decoder events
	input  wire logic              rs_block_in,
	input  wire logic              seg_err_in,
	input  wire logic              qam_mode_in,
	// Status and control
	output logic                   seg_err_over_threshold_out,
	output logic                   restart_req_out,
	output logic                   soft_reset_out,
	output logic                   irq_out
);

	function automatic logic [IVL_W-1:0] join_interval(input logic [7:0] top,
		input logic [7:0] mid, input logic [7:0] low);
		join_interval = {top, mid, low};
	endfunction

	// Register state
	logic              wait_r;
	logic [7:0]        readdata_r;
	logic [7:0]        vsb_low_r, vsb_mid_r, vsb_top_r;
	logic [7:0]        qam_low_r, qam_mid_r, qam_top_r;
	logic [7:0]        thr_low_r;
	logic [3:0]        thr_high_r;
	logic              auto_restart_disable_r;
	logic [7:0]        vsb_mid_act_r, qam_low_act_r, qam_mid_act_r;
	logic [THR_W-1:0]  thr_act_r;
	logic              soft_rst_r;
	logic [IVL_W-1:0]  blk_cnt_r;
	logic [ERR_W-1:0]  err_cnt_r, last_err_r, snap_err_r;
	logic              over_r, restart_r, interval_done_r;
	snap_state_t       snap_state_r;
	logic [4:0]        snap_idx_r;
	logic [7:0]        snap_status_r;
	logic [IRQ_W-1:0]  int_sts_r, int_mask_r;
	logic              irq_r;

	logic              wr_acc, rd_req;
	logic              snap_go, snap_done, boundary;
	logic [IVL_W-1:0]  vsb_ivl, qam_ivl, ivl_sel;
	logic [ERR_W-1:0]  err_final;
	logic              over_nxt;
	logic [7:0]        rd_mux;
	logic [IRQ_W-1:0]  irq_set;

	// A request is answered one cycle after it rises; reads are captured on that edge, writes land on the next
	assign wr_acc = write_in && !wait_r;
	assign rd_req = read_in && wait_r;

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_r <= 1'b1;
		end else if ((read_in || write_in) && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			readdata_r <= 8'h00;
		end else if (rd_req) begin
			readdata_r <= rd_mux;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		case (address_in)
			VSB_CTRL_IDX:    rd_mux = VSB_CTRL_FIXED | (8'(auto_restart_disable_r) << RESTART_DIS_BIT);
			VSB_LOW_IDX:     rd_mux = vsb_low_r;
			VSB_MID_IDX:     rd_mux = vsb_mid_r;
			VSB_TOP_IDX:     rd_mux = vsb_top_r;
			QAM_LOW_IDX:     rd_mux = qam_low_r;
			QAM_MID_IDX:     rd_mux = qam_mid_r;
			QAM_TOP_IDX:     rd_mux = qam_top_r;
			THR_LOW_IDX:     rd_mux = thr_low_r;
			THR_HIGH_IDX:    rd_mux = {4'h0, thr_high_r};
			SNAP_CTRL_IDX:   rd_mux = {7'h00, snap_state_r == SNAP_BUSY};
			RX_STATUS_IDX:   rd_mux = snap_status_r;
			INT_STATUS_IDX:  rd_mux = 8'(int_sts_r);
			INT_MASK_IDX:    rd_mux = 8'(int_mask_r);
			ERR_SNAP_LO_IDX: rd_mux = snap_err_r[7:0];
			ERR_SNAP_HI_IDX: rd_mux = 8'(snap_err_r >> 8);
			default:         rd_mux = 8'h00;
		endcase
	end

	// Host-written configuration
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vsb_low_r <= VSB_LOW_RST;
			vsb_mid_r <= VSB_MID_RST;
			vsb_top_r <= VSB_TOP_RST;
			qam_low_r <= QAM_LOW_RST;
			qam_mid_r <= QAM_MID_RST;
			qam_top_r <= QAM_TOP_RST;
			thr_low_r <= THR_LOW_RST;
			thr_high_r <= THR_HIGH_RST;
			auto_restart_disable_r <= 1'b0;
		end else if (wr_acc) begin
			case (address_in)
				VSB_CTRL_IDX: auto_restart_disable_r <= writedata_in[RESTART_DIS_BIT];
				VSB_LOW_IDX:  vsb_low_r <= writedata_in;
				VSB_MID_IDX:  vsb_mid_r <= writedata_in;
				VSB_TOP_IDX:  vsb_top_r <= writedata_in;
				QAM_LOW_IDX:  qam_low_r <= writedata_in;
				QAM_MID_IDX:  qam_mid_r <= writedata_in;
				QAM_TOP_IDX:  qam_top_r <= writedata_in;
				THR_LOW_IDX:  thr_low_r <= writedata_in;
				THR_HIGH_IDX: thr_high_r <= writedata_in[THR_HIGH_W-1:0];
				default: ;
			endcase
		end
	end

	// Any write to the soft reset register yields a one-cycle pulse
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_acc && (address_in == SOFT_RESET_IDX);
		end
	end

	// Deferred fields only move into use on a soft reset
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vsb_mid_act_r <= VSB_MID_RST;
			qam_low_act_r <= QAM_LOW_RST;
			qam_mid_act_r <= QAM_MID_RST;
			thr_act_r <= {THR_HIGH_RST, THR_LOW_RST};
		end else if (soft_rst_r) begin
			vsb_mid_act_r <= vsb_mid_r;
			qam_low_act_r <= qam_low_r;
			qam_mid_act_r <= qam_mid_r;
			thr_act_r <= {thr_high_r, thr_low_r};
		end
	end

	assign vsb_ivl = join_interval(vsb_top_r, vsb_mid_act_r, vsb_low_r);
	assign qam_ivl = join_interval(qam_top_r, qam_mid_act_r, qam_low_act_r);
	assign ivl_sel = qam_mode_in ? qam_ivl : vsb_ivl;

	// Interval closes on the block that reaches the count; zero acts as one
	assign boundary = rs_block_in && (blk_cnt_r + 24'h000001 >= ivl_sel);
	assign err_final = (seg_err_in && !(&err_cnt_r)) ? err_cnt_r + 1'b1 : err_cnt_r;
	assign over_nxt = err_final > ERR_W'(thr_act_r);

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			blk_cnt_r <= '0;
			err_cnt_r <= '0;
		end else if (soft_rst_r || boundary) begin
			blk_cnt_r <= '0;
			err_cnt_r <= '0;
		end else begin
			if (rs_block_in) begin
				blk_cnt_r <= blk_cnt_r + 24'h000001;
			end
			err_cnt_r <= err_final;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_err_r <= '0;
			over_r <= 1'b0;
			restart_r <= 1'b0;
			interval_done_r <= 1'b0;
		end else begin
			interval_done_r <= boundary && !soft_rst_r;
			restart_r <= boundary && !soft_rst_r && over_nxt && !qam_mode_in
				&& !auto_restart_disable_r;
			if (soft_rst_r) begin
				over_r <= 1'b0;
				last_err_r <= '0;
			end else if (boundary) begin
				over_r <= over_nxt;
				last_err_r <= err_final;
			end
		end
	end

	// Snapshot sequencer; a new request in the final cycle restarts the walk
	assign snap_go = wr_acc && (address_in == SNAP_CTRL_IDX) && writedata_in[SNAP_REQ_BIT];
	assign snap_done = (snap_state_r == SNAP_BUSY) && (snap_idx_r == SNAP_SPAN) && !snap_go;

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			snap_state_r <= SNAP_IDLE;
			snap_idx_r <= 5'h00;
		end else begin
			case (snap_state_r)
				SNAP_IDLE: begin
					snap_idx_r <= 5'h00;
					if (snap_go) begin
						snap_state_r <= SNAP_BUSY;
					end
				end
				SNAP_BUSY: begin
					if (snap_go) begin
						snap_idx_r <= 5'h00;
					end else if (snap_done) begin
						snap_state_r <= SNAP_IDLE;
						snap_idx_r <= 5'h00;
					end else begin
						snap_idx_r <= snap_idx_r + 5'h01;
					end
				end
				default: begin
					snap_state_r <= SNAP_IDLE;
					snap_idx_r <= 5'h00;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			snap_status_r <= 8'h00;
			snap_err_r <= '0;
		end else if (snap_done) begin
			snap_status_r <= 8'(over_r) << OVER_THR_BIT;
			snap_err_r <= last_err_r;
		end
	end

	// Interrupts: sticky, write one to clear, set wins over clear
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_INTERVAL] = interval_done_r;
		irq_set[IRQ_OVER] = interval_done_r && over_r;
		irq_set[IRQ_RESTART] = restart_r;
		irq_set[IRQ_SNAP] = snap_done;
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			int_sts_r <= '0;
			int_mask_r <= '0;
			irq_r <= 1'b0;
		end else begin
			if (wr_acc && address_in == INT_STATUS_IDX) begin
				int_sts_r <= (int_sts_r & ~writedata_in[IRQ_W-1:0]) | irq_set;
			end else begin
				int_sts_r <= int_sts_r | irq_set;
			end
			if (wr_acc && address_in == INT_MASK_IDX) begin
				int_mask_r <= writedata_in[IRQ_W-1:0];
			end
			irq_r <= |(int_sts_r & int_mask_r);
		end
	end

	assign readdata_out = readdata_r;
	assign waitrequest_out = wait_r;
	assign seg_err_over_threshold_out = over_r;
	assign restart_req_out = restart_r;
	assign soft_reset_out = soft_rst_r;
	assign irq_out = irq_r;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);

	chk_blk_count_step: assert property (
		(rs_block_in && !boundary && !soft_rst_r) |=> blk_cnt_r == $past(blk_cnt_r) + 24'h000001)
		else $error("block counter did not advance inside interval");

	chk_vsb_top_write: assert property (
		(wr_acc && address_in == VSB_TOP_IDX) |=> ##1 (rd_req && address_in == VSB_TOP_IDX)
		|=> readdata_out == $past(writedata_in, 3))
		else $error("VSB top byte readback differs from write");

	chk_cfg_deferred: assert property (
		!soft_rst_r |=> $stable(thr_act_r) && $stable(qam_mid_act_r) && $stable(qam_low_act_r)
		&& $stable(vsb_mid_act_r))
		else $error("deferred setting changed without soft reset");

	chk_cfg_applied: assert property (
		soft_rst_r |=> thr_act_r == {$past(thr_high_r), $past(thr_low_r)}
		&& qam_ivl == {qam_top_r, $past(qam_mid_r), $past(qam_low_r)})
		else $error("soft reset did not apply settings");

	chk_reserved_zero: assert property (
		(rd_req && (address_in == THR_HIGH_IDX || address_in == SNAP_CTRL_IDX))
		|=> readdata_out[7:4] == 4'h0 && (address_in != SNAP_CTRL_IDX || readdata_out[7:1] == 7'h00))
		else $error("reserved bits read nonzero");

	chk_snap_start: assert property (
		(snap_go && snap_state_r == SNAP_IDLE) |=> (snap_state_r == SNAP_BUSY)[*8])
		else $error("snapshot request bit dropped early");

	chk_snap_finish: assert property (
		$fell(snap_state_r == SNAP_BUSY) |-> $past(snap_idx_r) == SNAP_SPAN
		&& snap_status_r[OVER_THR_BIT] == $past(over_r))
		else $error("snapshot ended without full refresh");

	chk_over_compare: assert property (
		(boundary && !soft_rst_r) |=> over_r == ($past(err_final) > ERR_W'($past(thr_act_r)))
		&& err_cnt_r == '0 && blk_cnt_r == '0)
		else $error("interval close compare or clear wrong");

	chk_auto_restart: assert property (
		restart_r |-> $past(boundary) && !$past(qam_mode_in) && !$past(auto_restart_disable_r)
		&& over_r)
		else $error("restart without VSB over threshold");

	chk_irq_level: assert property (
		(|(int_sts_r & int_mask_r)) |=> irq_out)
		else $error("interrupt not raised for unmasked status");

	chk_irq_drop: assert property (
		!(|(int_sts_r & int_mask_r)) |=> !irq_out)
		else $error("interrupt high with no unmasked status");

	// An event always lands, even when software clears the same bit
	chk_irq_set_wins: assert property (
		(|irq_set) |=> (int_sts_r & $past(irq_set)) == $past(irq_set))
		else $error("interrupt event lost against a clear");

	cov_snapshot: cover property (snap_go ##[1:40] snap_done);
	cov_restart: cover property (restart_r);
	cov_soft_reset: cover property (soft_rst_r ##[1:100] interval_done_r);
	cov_qam_interval: cover property (qam_mode_in && boundary);

endmodule
`default_nettype wire

// ==== shared/fec_mon_pkg.sv ====
`default_nettype none
package fec_mon_pkg;

	// Register indices; the Avalon word address equals the index
	localparam logic [7:0] SOFT_RESET_IDX   = 8'h00;
	localparam logic [7:0] VSB_CTRL_IDX     = 8'h03;
	localparam logic [7:0] VSB_LOW_IDX      = 8'h1b;
	localparam logic [7:0] VSB_MID_IDX      = 8'h1c;
	localparam logic [7:0] VSB_TOP_IDX      = 8'h1d;
	localparam logic [7:0] QAM_LOW_IDX      = 8'h1e;
	localparam logic [7:0] QAM_MID_IDX      = 8'h1f;
	localparam logic [7:0] QAM_TOP_IDX      = 8'h20;
	localparam logic [7:0] THR_LOW_IDX      = 8'h21;
	localparam logic [7:0] THR_HIGH_IDX     = 8'h22;
	localparam logic [7:0] SNAP_CTRL_IDX    = 8'h25;
	localparam logic [7:0] RX_STATUS_IDX    = 8'h26;
	localparam logic [7:0] STATUS_LAST_IDX  = 8'h45;
	localparam logic [7:0] INT_STATUS_IDX   = 8'h50;
	localparam logic [7:0] INT_MASK_IDX     = 8'h51;
	localparam logic [7:0] ERR_SNAP_LO_IDX  = 8'h52;
	localparam logic [7:0] ERR_SNAP_HI_IDX  = 8'h53;

	// Reset values
	localparam logic [7:0] VSB_CTRL_FIXED   = 8'h02;
	localparam logic [7:0] VSB_LOW_RST      = 8'hbc;
	localparam logic [7:0] VSB_MID_RST      = 8'h64;
	localparam logic [7:0] VSB_TOP_RST      = 8'h00;
	localparam logic [7:0] QAM_LOW_RST      = 8'h00;
	localparam logic [7:0] QAM_MID_RST      = 8'h08;
	localparam logic [7:0] QAM_TOP_RST      = 8'h00;
	localparam logic [7:0] THR_LOW_RST      = 8'h05;
	localparam logic [3:0] THR_HIGH_RST     = 4'h0;

	// Field positions and widths
	localparam int RESTART_DIS_BIT = 4;
	localparam int SNAP_REQ_BIT    = 0;
	localparam int OVER_THR_BIT    = 3;
	localparam int THR_HIGH_W      = 4;
	localparam int THR_W           = 12;
	localparam int IVL_W           = 24;

	// Interrupt status and mask layout
	localparam int IRQ_W        = 4;
	localparam int IRQ_INTERVAL = 0;
	localparam int IRQ_OVER     = 1;
	localparam int IRQ_RESTART  = 2;
	localparam int IRQ_SNAP     = 3;

	// Snapshot walks one status register per cycle
	localparam logic [4:0] SNAP_SPAN = 5'(STATUS_LAST_IDX - RX_STATUS_IDX);

	typedef enum logic [0:0] {
		SNAP_IDLE = 1'b0,
		SNAP_BUSY = 1'b1
	} snap_state_t;

endpackage
`default_nettype wire

// ==== verification/fec_event_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module fec_event_source (
	// Clock
	input  wire logic clk_in,
	// Decoder events
	output logic      rs_block_out,
	output logic      seg_err_out
);
	initial begin
		rs_block_out = 1'b0;
		seg_err_out  = 1'b0;
	end

	// Errors fall in the first block; every block ends with its pulse
	task automatic run(input int blocks, input int errs);
		for (int b = 0; b < blocks; b++) begin
			for (int e = 0; e < errs && b == 0; e++) begin
				@(posedge clk_in);
				seg_err_out <= 1'b1;
				@(posedge clk_in);
				seg_err_out <= 1'b0;
			end
			@(posedge clk_in);
			rs_block_out <= 1'b1;
			@(posedge clk_in);
			rs_block_out <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_fec_error_monitor_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_fec_error_monitor_regs;
	import fec_mon_pkg::*;
	logic       core_clk_in  = 1'b0;
	logic       rstn_in      = 1'b0;
	logic [7:0] address_in   = 8'h00;
	logic       read_in      = 1'b0;
	logic       write_in     = 1'b0;
	logic [7:0] writedata_in = 8'h00;
	logic       qam_mode_in  = 1'b0;
	wire  [7:0] readdata_out;
	wire        waitrequest_out;
	wire        rs_block;
	wire        seg_err;
	wire        over;
	wire        restart_req;
	wire        soft_reset;
	wire        irq_out;
	int         errors       = 0;
	int         total_checks = 0;
	int         cyc          = 0;
	int         restarts     = 0;
	int         softs        = 0;
	int         r;
	int         n;
	logic [7:0] q;
	logic [7:0] ra[4] = '{VSB_TOP_IDX, QAM_LOW_IDX, QAM_MID_IDX, QAM_TOP_IDX};

	fec_error_monitor_regs uut (
		.core_clk_in               (core_clk_in),
		.rstn_in                   (rstn_in),
		.address_in                (address_in),
		.read_in                   (read_in),
		.write_in                  (write_in),
		.writedata_in              (writedata_in),
		.readdata_out              (readdata_out),
		.waitrequest_out           (waitrequest_out),
		.rs_block_in               (rs_block),
		.seg_err_in                (seg_err),
		.qam_mode_in               (qam_mode_in),
		.seg_err_over_threshold_out(over),
		.restart_req_out           (restart_req),
		.soft_reset_out            (soft_reset),
		.irq_out                   (irq_out)
	);

	fec_event_source dec (
		.clk_in      (core_clk_in),
		.rs_block_out(rs_block),
		.seg_err_out (seg_err)
	);

	always #2 core_clk_in = ~core_clk_in;

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Pulse counters and hang guard
	always @(posedge core_clk_in) begin
		cyc++;
		if (restart_req === 1'b1)
			restarts++;
		if (soft_reset === 1'b1)
			softs++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		address_in <= a;
		writedata_in <= d;
		read_in <= !wr;
		write_in <= wr;
		do begin
			@(posedge core_clk_in);
		end while (waitrequest_out !== 1'b0);
		q = readdata_out;
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge core_clk_in);
	endtask

	initial begin
		repeat (20) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		rd_chk(VSB_TOP_IDX, 8'h00);
		rd_chk(VSB_LOW_IDX, 8'hbc);
		rd_chk(VSB_MID_IDX, 8'h64);
		rd_chk(QAM_LOW_IDX, 8'h00);
		rd_chk(QAM_MID_IDX, 8'h08);
		rd_chk(QAM_TOP_IDX, 8'h00);
		rd_chk(THR_LOW_IDX, 8'h05);
		rd_chk(THR_HIGH_IDX, 8'h00);
		rd_chk(SNAP_CTRL_IDX, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ra[i], 8'ha5 ^ 8'(i));
			rd_chk(ra[i], 8'ha5 ^ 8'(i));
		end
		wr(THR_HIGH_IDX, 8'hff);
		rd_chk(THR_HIGH_IDX, 8'h0f);
		wr(SNAP_CTRL_IDX, 8'hfe);
		rd_chk(SNAP_CTRL_IDX, 8'h00);
		rd_chk(8'h70, 8'h00);
		// Two-block VSB and three-block QAM windows, threshold five
		wr(VSB_MID_IDX, 8'h00);
		wr(VSB_LOW_IDX, 8'h02);
		wr(VSB_TOP_IDX, 8'h00);
		wr(QAM_MID_IDX, 8'h00);
		wr(QAM_LOW_IDX, 8'h03);
		wr(QAM_TOP_IDX, 8'h00);
		wr(THR_HIGH_IDX, 8'h00);
		r = softs;
		wr(SOFT_RESET_IDX, 8'h00);
		settle();
		chk(8'(softs - r), 8'h01);
		// Threshold zero written but not yet applied
		wr(THR_LOW_IDX, 8'h00);
		rd_chk(THR_LOW_IDX, 8'h00);
		wr(INT_MASK_IDX, 8'h00);
		dec.run(2, 1);
		settle();
		chk(8'(over), 8'h00);
		wr(SOFT_RESET_IDX, 8'h00);
		wr(INT_STATUS_IDX, 8'hff);
		r = restarts;
		dec.run(2, 1);
		settle();
		chk(8'(over), 8'h01);
		chk(8'(restarts - r), 8'h01);
		rd_chk(INT_STATUS_IDX, 8'h07);
		chk(8'(irq_out), 8'h00);
		wr(INT_MASK_IDX, 8'h02);
		settle();
		chk(8'(irq_out), 8'h01);
		wr(INT_STATUS_IDX, 8'h02);
		settle();
		chk(8'(irq_out), 8'h00);
		rd_chk(INT_STATUS_IDX, 8'h05);
		// Snapshot: busy, poll until clear, then status holds the flag
		wr(SNAP_CTRL_IDX, 8'h01);
		rd_chk(SNAP_CTRL_IDX, 8'h01);
		n = 0;
		do begin
			bus(1'b0, SNAP_CTRL_IDX, 8'h00);
			n++;
		end while (q[SNAP_REQ_BIT] !== 1'b0 && n < 40);
		chk(q, 8'h00);
		rd_chk(RX_STATUS_IDX, 8'h08);
		rd_chk(ERR_SNAP_LO_IDX, 8'h01);
		rd_chk(ERR_SNAP_HI_IDX, 8'h00);
		rd_chk(INT_STATUS_IDX, 8'h0d);
		dec.run(2, 0);
		settle();
		chk(8'(over), 8'h00);
		// Restart disabled
		wr(VSB_CTRL_IDX, 8'h12);
		rd_chk(VSB_CTRL_IDX, 8'h12);
		r = restarts;
		dec.run(2, 1);
		settle();
		chk(8'(over), 8'h01);
		chk(8'(restarts - r), 8'h00);
		// QAM window closes on the third block only
		qam_mode_in <= 1'b1;
		wr(INT_STATUS_IDX, 8'hff);
		dec.run(2, 0);
		settle();
		rd_chk(INT_STATUS_IDX, 8'h00);
		dec.run(1, 0);
		settle();
		rd_chk(INT_STATUS_IDX, 8'h01);
		report_and_stop();
	end
endmodule
`default_nettype wire
